// *** logic/rail_enable_sequencer_reset.sv ***
`timescale 1ns/1ps
module rail_enable_sequencer_reset
	import seq_pkg::*;
#(
	parameter int unsigned BOR_CYCLES = BOR_DELAY_CYC,
	parameter int unsigned TICK_CYCLES = MS_TICK_CYC
) (
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	input  wire logic                     ext_reset_pin_n,
	input  wire logic                     restart_cmd,
	input  wire logic                     sequence_fault,
	input  wire logic                     config_loaded,
	input  wire logic                     checksum_ok,
	input  wire logic                     checksum_done,
	input  wire logic                     copy_done,
	input  wire logic                     ref_select_internal,
	input  wire logic                     shared_as_gpo,
	input  wire out_cfg_t [NUM_OUT-1:0]   out_cfg,
	input  wire rail_mon_t [NUM_RAILS-1:0] rail_mon,
	input  wire logic                     shared_enable_strap_pin_in,
	input  wire logic [ADDR_W-2:0]        bus_address_straps,
	input  wire logic                     bus_scl_in,
	input  wire logic                     bus_sda_in,
	output logic [NUM_RAILS-1:0]          rail_enable_out,
	output logic [NUM_RAILS-1:0]          rail_enable_oe_n,
	output logic [NUM_GPO-1:0]            general_out,
	output logic [NUM_GPO-1:0]            general_oe_n,
	output logic [ADDR_W-1:0]             bus_address,
	output logic                          bus_enable,
	output logic                          bus_scl_hold_low,
	output logic                          checksum_start,
	output logic                          restore_start,
	output logic                          backup_start,
	output logic                          use_internal_ref,
	output logic                          in_reset
);
	// ==========================================================
	// input synchronisers
	logic [1:0] pin_sync_r;
	logic [1:0] strap_sync_r [ADDR_W];
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic       pin_low;
	logic [ADDR_W-1:0] strap_raw;

	assign strap_raw = {bus_address_straps, shared_enable_strap_pin_in};

	// two flops for every pin level
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_sync_r <= 2'h3;
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			for (int i = 0; i < ADDR_W; i++) begin
				strap_sync_r[i] <= 2'h0;
			end
		end else begin
			pin_sync_r <= {pin_sync_r[0], ext_reset_pin_n};
			scl_sync_r <= {scl_sync_r[0], bus_scl_in};
			sda_sync_r <= {sda_sync_r[0], bus_sda_in};
			for (int i = 0; i < ADDR_W; i++) begin
				strap_sync_r[i] <= {strap_sync_r[i][0], strap_raw[i]};
			end
		end
	end
	assign pin_low = !pin_sync_r[1];

	// ==========================================================
	// reset causes
	localparam int unsigned PULSE_W = $clog2(RST_PULSE_CYC + 1);
	localparam int unsigned BOR_W   = $clog2(BOR_CYCLES + 2);
	logic [PULSE_W-1:0] pulse_cnt_r;
	logic               pin_reset;
	logic [BOR_W-1:0]   bor_cnt_r;
	logic               bor_done;
	logic               reset_req;

	// low pulse must last 2 us before it is taken
	always_ff @(posedge sys_clk) begin
		if (!resetn || !pin_low) begin
			pulse_cnt_r <= '0;
		end else if (pulse_cnt_r != PULSE_W'(RST_PULSE_CYC)) begin
			pulse_cnt_r <= pulse_cnt_r + 1'b1;
		end
	end
	assign pin_reset = pulse_cnt_r == PULSE_W'(RST_PULSE_CYC);

	// power-on wait after brownout release, resetn models the brownout signal
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bor_cnt_r <= '0;
		end else if (!bor_done) begin
			bor_cnt_r <= bor_cnt_r + 1'b1;
		end
	end
	assign bor_done = bor_cnt_r == BOR_W'(BOR_CYCLES);

	// any cause restarts the reset procedure
	assign reset_req = pin_reset || restart_cmd || sequence_fault;

	// ==========================================================
	// backup needed after a new configuration
	logic backup_pending_r;
	logic backup_sent_r;
	logic ans_fresh;
	logic run;
	rst_state_t state_r;
	rst_state_t state_nxt;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			backup_pending_r <= 1'b0;
		end else if (config_loaded) begin
			backup_pending_r <= 1'b1; // set wins over clear
		end else if (state_r == ST_CHECK && ans_fresh && checksum_ok && backup_sent_r && copy_done) begin
			backup_pending_r <= 1'b0;
		end
	end

	// done levels linger from the last pass until the helper sees a new start
	assign ans_fresh = checksum_done && !checksum_start;

	// one backup request per check; copy answer trusted only after it
	always_ff @(posedge sys_clk) begin
		if (!resetn || state_r != ST_CHECK) begin
			backup_sent_r <= 1'b0;
		end else if (backup_start) begin
			backup_sent_r <= 1'b1;
		end
	end

	// ==========================================================
	// reset sequence
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_HIZ:      state_nxt = bor_done ? ST_CLR : ST_HIZ;
			ST_CLR:      state_nxt = ST_STRAP;
			ST_STRAP:    state_nxt = ST_INACTIVE;
			ST_INACTIVE: state_nxt = ST_CHECK;
			ST_CHECK: begin
				if (ans_fresh && !checksum_ok) begin
					state_nxt = ST_RESTORE;
				end else if (ans_fresh && (!backup_pending_r || (backup_sent_r && copy_done))) begin
					state_nxt = ST_RUN;
				end
			end
			ST_RESTORE:  state_nxt = (copy_done && !restore_start) ? ST_RUN : ST_RESTORE;
			ST_RUN:      state_nxt = ST_RUN;
			default:     state_nxt = ST_HIZ;
		endcase
		if (reset_req) begin
			state_nxt = ST_HIZ;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_r <= ST_HIZ;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign run = state_r == ST_RUN;

	// one-cycle starts of the memory helpers
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			checksum_start <= 1'b0;
			restore_start  <= 1'b0;
			backup_start   <= 1'b0;
		end else begin
			checksum_start <= state_r == ST_INACTIVE && !reset_req;
			restore_start  <= state_r == ST_CHECK && ans_fresh && !checksum_ok && !reset_req;
			backup_start   <= state_r == ST_CHECK && ans_fresh && checksum_ok
				&& backup_pending_r && !reset_req && !backup_start && !backup_sent_r;
		end
	end

	// ==========================================================
	// address strap capture and bus gating
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bus_address <= '0;
		end else if (state_r == ST_STRAP) begin
			for (int i = 0; i < ADDR_W; i++) begin
				bus_address[i] <= strap_sync_r[i][1];
			end
		end
	end

	// slave only; clock line never held low, bus_scl_hold_low stays 0
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			bus_enable       <= 1'b0;
			bus_scl_hold_low <= 1'b0;
			in_reset         <= 1'b1;
		end else begin
			bus_enable       <= state_nxt == ST_RUN;
			bus_scl_hold_low <= 1'b0;
			in_reset         <= state_nxt != ST_RUN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			use_internal_ref <= 1'b1;
		end else begin
			use_internal_ref <= ref_select_internal;
		end
	end

	// ==========================================================
	// millisecond tick
	localparam int unsigned TICK_W = $clog2(TICK_CYCLES + 1);
	logic [TICK_W-1:0] tick_cnt_r;
	logic              ms_tick;
	logic              timers_clear;

	assign timers_clear = state_r == ST_CLR || reset_req;

	always_ff @(posedge sys_clk) begin
		if (!resetn || timers_clear || !run) begin
			tick_cnt_r <= '0;
		end else if (tick_cnt_r == TICK_W'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end
	assign ms_tick = run && tick_cnt_r == TICK_W'(TICK_CYCLES - 1);

	// ==========================================================
	// parent regulation window
	logic [NUM_RAILS-1:0] in_reg;
	always_comb begin
		for (int i = 0; i < NUM_RAILS; i++) begin
			in_reg[i] = rail_mon[i].volt >= rail_mon[i].uv_limit
				&& rail_mon[i].volt <= rail_mon[i].ov_limit;
		end
	end

	// ==========================================================
	// sequencing channels: 0..7 enables (7 also gpo 1), 8..10 gpo 2..4
	logic [NUM_OUT-1:0] assert_ch;
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_ch
		seq_channel u_ch (
			.sys_clk       (sys_clk),
			.resetn        (resetn),
			.clear         (timers_clear),
			.run           (run),
			.ms_tick       (ms_tick),
			.cfg           (out_cfg[g]),
			.parent_in_reg (in_reg),
			.parent_volt   (rail_mon[out_cfg[g].parent].volt),
			.asserted      (assert_ch[g])
		);
	end

	function automatic logic drive_level(input logic on, input logic active_high);
		drive_level = active_high ? on : !on;
	endfunction

	// ==========================================================
	// pin drivers
	logic drive_en;
	assign drive_en = state_r == ST_INACTIVE || state_r == ST_CHECK || state_r == ST_RESTORE || run;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rail_enable_out  <= '0;
			rail_enable_oe_n <= '1;
			general_out      <= '0;
			general_oe_n     <= '1;
		end else begin
			for (int i = 0; i < NUM_RAILS; i++) begin
				rail_enable_out[i] <= drive_level(assert_ch[i] && run && !reset_req, out_cfg[i].active_high);
				rail_enable_oe_n[i] <= !(drive_en && !reset_req);
			end
			for (int j = 1; j < NUM_GPO; j++) begin
				general_out[j]  <= drive_level(assert_ch[NUM_RAILS+j-1] && run && !reset_req,
					out_cfg[NUM_RAILS+j-1].active_high);
				general_oe_n[j] <= !(drive_en && !reset_req);
			end
			// shared pin: one driver, reported on the port of its role
			general_out[0]  <= drive_level(assert_ch[NUM_RAILS-1] && run && !reset_req,
				out_cfg[NUM_RAILS-1].active_high);
			general_oe_n[0] <= !(drive_en && !reset_req && shared_as_gpo);
			if (shared_as_gpo) begin
				rail_enable_oe_n[NUM_RAILS-1] <= 1'b1;
			end
		end
	end
endmodule

// *** logic/seq_pkg.sv ***
package seq_pkg;
	// ==========================================================
	// timing, sizes and mode codes
	localparam int unsigned CLK_HZ            = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS     = 8;
	localparam int unsigned RST_PULSE_MIN_NS  = 2_000;          // 2 us minimum reset pulse
	localparam int unsigned RST_PULSE_CYC     = (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BOR_DELAY_US      = 2_000;          // longest wait after brownout release
	localparam int unsigned BOR_DELAY_CYC     = (BOR_DELAY_US * 1_000) / CLK_PERIOD_NS;
	localparam int unsigned MS_TICK_US        = 1_000;
	localparam int unsigned MS_TICK_CYC       = (MS_TICK_US * 1_000) / CLK_PERIOD_NS;
	localparam int unsigned NUM_RAILS         = 8;
	localparam int unsigned NUM_GPO           = 4;
	localparam int unsigned NUM_OUT           = NUM_RAILS + NUM_GPO - 1; // enable 8 is shared with gpo 1
	localparam int unsigned VOLT_W            = 10;
	localparam int unsigned DELAY_W           = 12;
	localparam int unsigned RAIL_IDX_W        = 3;
	localparam int unsigned ADDR_W            = 4;
	localparam logic [2:0]  MODE_OFF          = 3'h0;
	localparam logic [2:0]  MODE_TIME         = 3'h1;
	localparam logic [2:0]  MODE_PARENT_REG   = 3'h2;
	localparam logic [2:0]  MODE_PARENT_THR   = 3'h4;

	// per output sequencing setup
	typedef struct packed {
		logic [2:0]            mode;
		logic                  active_high;
		logic [RAIL_IDX_W-1:0] parent;
		logic [DELAY_W-1:0]    delay_ms;
		logic [VOLT_W-1:0]     threshold;
	} out_cfg_t;

	// per rail monitor limits and reading
	typedef struct packed {
		logic [VOLT_W-1:0] volt;
		logic [VOLT_W-1:0] uv_limit;
		logic [VOLT_W-1:0] ov_limit;
	} rail_mon_t;

	typedef enum logic [6:0] {
		ST_HIZ      = 7'b000_0001,
		ST_CLR      = 7'b000_0010,
		ST_STRAP    = 7'b000_0100,
		ST_INACTIVE = 7'b000_1000,
		ST_CHECK    = 7'b001_0000,
		ST_RESTORE  = 7'b010_0000,
		ST_RUN      = 7'b100_0000
	} rst_state_t;
endpackage

// *** logic/seq_channel.sv ***
`timescale 1ns/1ps
// one sequenced output: decides when its asserted state is reached
module seq_channel
	import seq_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 resetn,
	input  wire logic                 clear,
	input  wire logic                 run,
	input  wire logic                 ms_tick,
	input  wire out_cfg_t             cfg,
	input  wire logic [NUM_RAILS-1:0] parent_in_reg,
	input  wire logic [VOLT_W-1:0]    parent_volt,
	output logic                      asserted
);
	logic [DELAY_W-1:0] count_r;
	logic               armed;
	logic               start;

	// the count starts from reset release or from the parent event
	always_comb begin
		case (cfg.mode)
			MODE_TIME:       start = 1'b1;
			MODE_PARENT_REG: start = parent_in_reg[cfg.parent];
			default:         start = 1'b0;
		endcase
	end
	assign armed = run && start;

	// millisecond delay counter
	always_ff @(posedge sys_clk) begin
		if (!resetn || clear || !armed) begin
			count_r <= '0;
		end else if (ms_tick && count_r != cfg.delay_ms) begin
			count_r <= count_r + 1'b1;
		end
	end

	// assertion decision, latched until the next reset
	always_ff @(posedge sys_clk) begin
		if (!resetn || clear || !run) begin
			asserted <= 1'b0;
		end else begin
			case (cfg.mode)
				MODE_TIME, MODE_PARENT_REG: if (armed && count_r == cfg.delay_ms) asserted <= 1'b1;
				MODE_PARENT_THR:            if (parent_volt >= cfg.threshold) asserted <= 1'b1;
				default:                    asserted <= 1'b0;
			endcase
		end
	end
endmodule

// *** tb/mem_bus_partner.sv ***
`timescale 1ns/1ps
// memory helper and idle two-wire master beside the sequencer
module mem_bus_partner (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       checksum_start,
	input  wire logic       restore_start,
	input  wire logic       backup_start,
	input  wire logic       bus_scl_hold_low,
	input  wire logic       cfg_bad,
	input  wire logic [4:0] lat,
	output logic            checksum_done,
	output logic            checksum_ok,
	output logic            copy_done,
	output logic            scl,
	output logic            sda
);
	logic [4:0] cs_r;
	logic [4:0] cp_r;

	// ==========================================================
	// checksum answer lat cycles after each request
	always_ff @(posedge sys_clk) begin
		if (!resetn || checksum_start) begin
			checksum_done <= 1'b0;
			cs_r          <= resetn ? lat : 5'h00;
		end else if (cs_r != 5'h00) begin
			cs_r          <= cs_r - 5'h01;
			checksum_done <= (cs_r == 5'h01);
		end
	end
	// verdict only meaningful with done; toggles otherwise
	assign checksum_ok = checksum_done ? !cfg_bad : cs_r[0];

	// copy answer for restore and backup alike
	always_ff @(posedge sys_clk) begin
		if (!resetn || restore_start || backup_start) begin
			copy_done <= 1'b0;
			cp_r      <= resetn ? lat : 5'h00;
		end else if (cp_r != 5'h00) begin
			cp_r      <= cp_r - 5'h01;
			copy_done <= (cp_r == 5'h01);
		end
	end

	// idle master: clock line follows any stretch, data released high
	assign scl = !bus_scl_hold_low;
	assign sda = 1'b1;
endmodule

// *** tb/rail_enable_sequencer_reset_properties.sv ***
`timescale 1ns/1ps
// port-level checks of the sequencer and its reset walk
module seq_rules_checker
	import seq_pkg::*;
(
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	input  wire logic                     ext_reset_pin_n,
	input  wire logic                     restart_cmd,
	input  wire logic                     sequence_fault,
	input  wire logic                     checksum_done,
	input  wire logic                     checksum_ok,
	input  wire logic                     shared_as_gpo,
	input  wire out_cfg_t [NUM_OUT-1:0]   out_cfg,
	input  wire logic [NUM_RAILS-1:0]     rail_enable_out,
	input  wire logic [NUM_RAILS-1:0]     rail_enable_oe_n,
	input  wire logic [NUM_GPO-1:0]       general_out,
	input  wire logic [NUM_GPO-1:0]       general_oe_n,
	input  wire logic                     bus_enable,
	input  wire logic                     bus_scl_hold_low,
	input  wire logic                     checksum_start,
	input  wire logic                     restore_start,
	input  wire logic                     in_reset
);
	localparam int PIN_MIN = RST_PULSE_CYC;
	logic [NUM_OUT-1:0] inact;
	logic [NUM_OUT-1:0] quiet;
	logic [8:0]         low_r;
	logic [3:0]         oth_r;

	// ==========================================================
	// inactive levels and channels that must stay inactive
	always_comb begin
		for (int i = 0; i < NUM_OUT; i++) begin
			inact[i] = ~out_cfg[i].active_high;
			quiet[i] = in_reset | !(out_cfg[i].mode inside {MODE_TIME, MODE_PARENT_REG, MODE_PARENT_THR});
		end
	end
	// length of the current low level on the reset pin
	always_ff @(posedge sys_clk) begin
		if (ext_reset_pin_n) begin
			low_r <= 9'h000;
		end else if (low_r != 9'h1ff) begin
			low_r <= low_r + 9'h001;
		end
	end
	// recent command or fault causes
	always_ff @(posedge sys_clk) begin
		oth_r <= {oth_r[2:0], restart_cmd | sequence_fault};
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_enable_quiet: assert property (((rail_enable_out ^ inact[7:0]) & ~rail_enable_oe_n
		& quiet[7:0]) == '0)
		else $error("enable left inactive level");
	a_gpo_quiet: assert property (((general_out ^ inact[10:7]) & ~general_oe_n
		& quiet[10:7]) == '0)
		else $error("general output left inactive level");
	a_shared_float: assert property (shared_as_gpo && $past(shared_as_gpo) |-> rail_enable_oe_n[7])
		else $error("shared pin driven as enable");
	a_bus_in_run: assert property (bus_enable |-> !in_reset)
		else $error("bus served during reset");
	a_no_stretch: assert property (!bus_scl_hold_low)
		else $error("clock line held low");
	a_check_order: assert property (checksum_start |-> in_reset && rail_enable_oe_n[6:0] == '0)
		else $error("checksum before outputs driven");
	a_restore_fail: assert property ($rose(checksum_done) && !checksum_ok && in_reset
		|-> ##[1:3] restore_start)
		else $error("no restore after bad checksum");
	a_restore_cause: assert property (restore_start |-> checksum_done && !checksum_ok)
		else $error("restore without bad checksum");
	a_pin_short: assert property ($fell(bus_enable) && oth_r == 4'h0 |-> low_r >= PIN_MIN)
		else $error("short pin pulse accepted");
	a_pin_long: assert property (low_r == PIN_MIN + 8 |-> !bus_enable)
		else $error("long pin pulse ignored");
	a_restart_cmd: assert property (restart_cmd |-> ##[1:3] in_reset)
		else $error("restart command ignored");
	a_fault_float: assert property (sequence_fault
		|-> ##[1:3] (&rail_enable_oe_n && &general_oe_n))
		else $error("outputs not released after fault");
endmodule

bind rail_enable_sequencer_reset seq_rules_checker seq_rules_checker_i (.sys_clk, .resetn, .ext_reset_pin_n,
	.restart_cmd, .sequence_fault, .checksum_done, .checksum_ok, .shared_as_gpo, .out_cfg, .rail_enable_out,
	.rail_enable_oe_n, .general_out, .general_oe_n, .bus_enable, .bus_scl_hold_low, .checksum_start,
	.restore_start, .in_reset);

// *** tb/rail_enable_sequencer_reset_bench.sv ***
`timescale 1ns/1ps
// random sequencing rounds plus reset-cause and checksum corners
module rail_enable_sequencer_reset_bench;
	import seq_pkg::*;
	localparam int TCK = 10;
	logic sys_clk, resetn, pin_n, restart_cmd, sequence_fault, config_loaded, ref_sel, shared, strap0, cfg_bad;
	logic bus_en, hold, cs_st, rs_st, bk_st, int_ref, in_rst, cs_done, cs_ok, cp_done, scl, sda, saw_rs, saw_bk;
	logic                      clr_saw;
	logic [2:0]                straps;
	logic [4:0]                lat;
	out_cfg_t [NUM_OUT-1:0]    cfg;
	rail_mon_t [NUM_RAILS-1:0] mon;
	logic [NUM_RAILS-1:0]      en, en_oe_n;
	logic [NUM_GPO-1:0]        gpo, gpo_oe_n;
	logic [ADDR_W-1:0]         addr;
	int                        err_total, n_tests;

	rail_enable_sequencer_reset #(.BOR_CYCLES(20), .TICK_CYCLES(TCK)) rail_enable_sequencer_reset_i (.sys_clk,
		.resetn, .ext_reset_pin_n(pin_n), .restart_cmd, .sequence_fault, .config_loaded, .checksum_ok(cs_ok),
		.checksum_done(cs_done), .copy_done(cp_done), .ref_select_internal(ref_sel), .shared_as_gpo(shared),
		.out_cfg(cfg), .rail_mon(mon), .shared_enable_strap_pin_in(strap0), .bus_address_straps(straps),
		.bus_scl_in(scl), .bus_sda_in(sda), .rail_enable_out(en), .rail_enable_oe_n(en_oe_n), .general_out(gpo),
		.general_oe_n(gpo_oe_n), .bus_address(addr), .bus_enable(bus_en), .bus_scl_hold_low(hold),
		.checksum_start(cs_st), .restore_start(rs_st), .backup_start(bk_st), .use_internal_ref(int_ref),
		.in_reset(in_rst));
	mem_bus_partner mem_bus_partner_i (.sys_clk, .resetn, .checksum_start(cs_st), .restore_start(rs_st),
		.backup_start(bk_st), .bus_scl_hold_low(hold), .cfg_bad, .lat, .checksum_done(cs_done),
		.checksum_ok(cs_ok), .copy_done(cp_done), .scl, .sda);

	// ==========================================================
	// clock, copy-request monitor, watchdog
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		saw_rs <= !clr_saw && (saw_rs || rs_st);
		saw_bk <= !clr_saw && (saw_bk || bk_st);
	end
	initial begin
		repeat (12000) @(posedge sys_clk);
		err_total++;
		close_out();
	end

	// ==========================================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic exp_on(int i);
		rail_mon_t m;
		m = mon[cfg[i].parent];
		case (cfg[i].mode)
			MODE_TIME:       return 1'b1;
			MODE_PARENT_REG: return m.volt >= m.uv_limit && m.volt <= m.ov_limit;
			MODE_PARENT_THR: return m.volt >= cfg[i].threshold;
			default:         return 1'b0;
		endcase
	endfunction
	task automatic rnd_cfg();
		for (int i = 0; i < NUM_OUT; i++) begin
			cfg[i]             = '0;
			cfg[i].mode        = MODE_TIME;
			cfg[i].active_high = 1'($urandom_range(1, 0));
			cfg[i].delay_ms    = 12'($urandom_range(3, 1));
			cfg[i].parent      = 3'h2;
		end
		mon[2].volt      = 10'($urandom_range(1000, 10));
		cfg[1].mode      = MODE_OFF;
		cfg[2].mode      = MODE_PARENT_REG;
		cfg[2].parent    = 3'h0;
		cfg[3].mode      = MODE_PARENT_REG;
		cfg[3].parent    = 3'h1;
		cfg[4].mode      = MODE_PARENT_THR;
		cfg[4].threshold = mon[2].volt;
		cfg[5].mode      = MODE_PARENT_THR;
		cfg[5].threshold = mon[2].volt + 10'h001;
		cfg[6].delay_ms  = 12'h000;
		cfg[9].mode      = 3'h3;
		{straps, strap0, shared, ref_sel} = 6'($urandom);
		lat              = 5'($urandom_range(6, 1));
	endtask
	task automatic wait_run();
		int k;
		k = 0;
		while (in_rst !== 1'b0 && k < 400) begin
			@(negedge sys_clk);
			k++;
		end
		chk(k < 400, 1);
	endtask
	task automatic run_check();
		int t0;
		logic [NUM_OUT-1:0] xl;
		t0 = -1;
		wait_run();
		chk(addr, {straps, strap0});
		chk(int_ref, ref_sel);
		for (int k = 0; k < 6 * TCK; k++) begin
			if (t0 < 0 && en[0] === cfg[0].active_high) begin
				t0 = k;
			end
			@(negedge sys_clk);
		end
		chk(t0 >= (cfg[0].delay_ms - 1) * TCK && t0 <= cfg[0].delay_ms * TCK + 4, 1);
		for (int i = 0; i < NUM_OUT; i++) begin
			xl[i] = exp_on(i) ? cfg[i].active_high : ~cfg[i].active_high;
		end
		chk(en, xl[7:0]);
		chk(gpo, xl[10:7]);
		chk(en_oe_n, {shared, 7'h00});
		chk(gpo_oe_n, {3'h0, ~shared});
	endtask
	task automatic kick(input logic [1:0] c);
		{sequence_fault, restart_cmd} = c;
		@(negedge sys_clk);
		{sequence_fault, restart_cmd} = 2'b00;
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic end_test(input string s);
		$display("test %0s done, checks %0d", s, n_tests);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{restart_cmd, sequence_fault, config_loaded, cfg_bad, clr_saw} = 5'h01;
		resetn    = 1'b0;
		pin_n     = 1'b1;
		err_total = 0;
		n_tests   = 0;
		mon       = '0;
		mon[0]    = {10'h0c8, 10'h064, 10'h12c};
		mon[1]    = {10'h020, 10'h064, 10'h12c};
		void'($urandom(32'hd780_f774));
		rnd_cfg();
		repeat (8) @(negedge sys_clk);
		resetn  = 1'b1;
		clr_saw = 1'b0;
		for (int r = 0; r < 3; r++) begin
			pin_n = 1'b0;
			repeat (RST_PULSE_CYC + 10) @(negedge sys_clk);
			chk({en_oe_n, gpo_oe_n, in_rst}, 13'h1fff);
			rnd_cfg();
			pin_n = 1'b1;
			run_check();
			end_test("pin reset round");
		end
		pin_n = 1'b0;
		repeat (RST_PULSE_CYC / 2) @(negedge sys_clk);
		pin_n = 1'b1;
		repeat (10) @(negedge sys_clk);
		chk({in_rst, bus_en}, 2'h1);
		end_test("short pulse");
		for (int c = 1; c < 3; c++) begin
			kick(2'(c));
			chk({in_rst, bus_en, en_oe_n, gpo_oe_n}, 14'h2fff);
			run_check();
			end_test("command reset");
		end
		cfg_bad = 1'b1;
		clr_saw = 1'b1;
		@(negedge sys_clk);
		clr_saw = 1'b0;
		kick(2'b01);
		run_check();
		chk(saw_rs, 1);
		end_test("restore");
		cfg_bad       = 1'b0;
		config_loaded = 1'b1;
		@(negedge sys_clk);
		config_loaded = 1'b0;
		for (int b = 1; b >= 0; b--) begin
			clr_saw = 1'b1;
			@(negedge sys_clk);
			clr_saw = 1'b0;
			kick(2'b01);
			wait_run();
			chk(saw_bk, b);
		end
		end_test("backup");
		close_out();
	end
endmodule
